// File: design/rtu_pkg.sv
// Shared constants, types and BCD helpers for the timestamp update control pair
`default_nettype none
package rtu_pkg;
   // Register offsets
   localparam logic [7:0] OFS_SUBSEC = 8'h00;
   localparam logic [7:0] OFS_SECONDS = 8'h01;
   localparam logic [7:0] OFS_CENT_HOURS = 8'h03;
   localparam logic [7:0] OFS_WEEKDAY = 8'h04;
   localparam logic [7:0] OFS_YEAR = 8'h07;
   localparam logic [7:0] OFS_CONTROL = 8'h08;
   localparam logic [7:0] OFS_HALT = 8'h0C;
   localparam logic [7:0] OFS_FLAGS = 8'h0F;
   localparam logic [7:0] OFS_TAMPER1 = 8'h14;
   localparam logic [7:0] OFS_TAMPER2 = 8'h15;
   // Field positions
   localparam int STOP_BIT = 7;
   localparam int HALT_BIT = 6;
   localparam int ARM_BIT = 7;
   localparam int SWITCH_BIT = 5;
   localparam int PULL_BIT = 2;
   localparam int FLAG1_BIT = 1;
   localparam int FLAG2_BIT = 0;
   // BCD limits
   localparam logic [7:0] BCD_SUBSEC_MAX = 8'h99;
   localparam logic [7:0] BCD_SEC_MAX = 8'h59;
   localparam logic [7:0] BCD_HOUR_MAX = 8'h23;
   localparam logic [7:0] BCD_DAY_MAX = 8'h07;
   localparam logic [7:0] BCD_MONTH_MAX = 8'h12;
   localparam logic [7:0] BCD_YEAR_MAX = 8'h99;
   localparam logic [7:0] BCD_ZERO = 8'h00;
   localparam logic [7:0] BCD_ONE = 8'h01;
   // Reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [7:0] RST_DAY = 8'h01;
   // Timing: hundredth-of-second tick at a 10 ns clock
   localparam int CLK_PERIOD_NS = 10;
   localparam int SUBSEC_PERIOD_NS = 10_000_000;
   localparam int SUBSEC_CYCLES_DFLT = SUBSEC_PERIOD_NS / CLK_PERIOD_NS;
   // Host-side Avalon word addresses and command word bits
   localparam logic [1:0] AVS_CMD = 2'h0;
   localparam logic [1:0] AVS_STATUS = 2'h1;
   localparam int CMD_WR_BIT = 16;
   localparam int CMD_STOP_BIT = 17;

   typedef enum logic [1:0] {HS_IDLE, HS_REQ, HS_STOP} rtu_hstate_t;

   // Next BCD value, wrapping from mx back to mn
   function automatic logic [7:0] rtu_bcd_next(input logic [7:0] v, input logic [7:0] mx, input logic [7:0] mn);
      if (v >= mx) begin
         return mn;
      end else if (v[3:0] == 4'h9) begin
         return {v[7:4] + 4'h1, 4'h0};
      end
      return v + 8'h01;
   endfunction

   // Last date of a month; leap years follow the two BCD year digits
   function automatic logic [7:0] rtu_month_days(input logic [7:0] mon, input logic [7:0] yr);
      logic leap;
      leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6) : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
      if (mon == 8'h02) begin
         return leap ? 8'h29 : 8'h28;
      end else if (mon == 8'h04 || mon == 8'h06 || mon == 8'h09 || mon == 8'h11) begin
         return 8'h30;
      end
      return 8'h31;
   endfunction
endpackage
`default_nettype wire

// File: design/rtu_if.sv
// Register access link between the host controller and the clock device
`default_nettype none
interface rtu_if;
   logic req;
   logic wr;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic ack;
   logic stop;
   modport dev (input req, input wr, input addr, input wdata, input stop, output rdata, output ack);
   modport host (output req, output wr, output addr, output wdata, output stop, input rdata, input ack);
endinterface
`default_nettype wire

// File: design/rtu_device.sv
// Clock device: internal time chain, user copies, freeze and tamper logic
//
// Added by the designer: the register link port; the Avalon-MM port is in the host controller.
`default_nettype none
//
// Contract
// - Pull size: bit one 1M, zero 10M
// - Tamper sets flag, freezes copies 00h-07h
// - Clearing arm clears flag, resumes updates
// - Host keeps arms zero for running time
// - Held stamp keeps the first event
// - Armed tamper blocks power-down halt setting
// - Clock write forces subseconds to 00
// - BCD layout, century bits, weekday bits
// - Stop bit halts oscillator, zero restarts
// - Clock write loads chain, resets divider
// - Host writes config bits before time
// - Bytes single or sequential; control alone
// - Clock reads suspend copy updates
// - Power return sets halt-update
// - Freeze zeroes 00h; internal time runs
// - Clearing halt-update resumes copying
// - Host saves power-down time itself
// - Flags read-only, cleared via arm
// - Stop or non-clock read resumes updates
// - Copies refreshed from incremented internal time
module rtu_device
   import rtu_pkg::*;
#(
   parameter int SUBSEC_CYCLES = SUBSEC_CYCLES_DFLT
) (
   input wire logic ref_clk,
   input wire logic rst,
   rtu_if.dev bus,
   input wire logic [1:0] tamper_input_pin,
   input wire logic power_up_event,
   output logic [1:0] pull_enable,
   output logic [1:0] pull_size_1m,
   output logic osc_running
);
   logic [7:0] int_r [8];
   logic [7:0] int_nxt [8];
   logic [7:0] usr_r [8];
   logic [7:0] usr_nxt [8];
   logic [31:0] div_r;
   logic [31:0] div_nxt;
   logic [7:0] ctrl_r;
   logic [7:0] ctrl_nxt;
   logic [2:0] tcfg_r [2];
   logic [2:0] tcfg_nxt [2];
   logic [1:0] flag_r;
   logic [1:0] flag_nxt;
   logic halt_r;
   logic halt_nxt;
   logic rdhold_r;
   logic rdhold_nxt;
   logic ack_r;
   logic ack_nxt;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;
   logic [1:0] tp_s1_r;
   logic [1:0] tp_s2_r;
   logic [1:0] pu_sync_r;
   logic pu_last_r;
   logic take;
   logic clk_wr;
   logic tick;
   logic frozen;
   logic [1:0] arm;

   assign take = bus.req && !ack_r;
   assign clk_wr = take && bus.wr && (bus.addr <= OFS_YEAR);
   assign arm = {tcfg_r[1][2], tcfg_r[0][2]};
   assign frozen = halt_r || (|flag_r);
   assign tick = (div_r == 32'(SUBSEC_CYCLES - 1)) && !int_r[1][STOP_BIT];
   assign bus.ack = ack_r;
   assign bus.rdata = rdata_r;
   assign osc_running = !int_r[1][STOP_BIT];

   // Pull resistor steering per channel, only for normally closed armed inputs
   generate
      for (genvar ch = 0; ch < 2; ch++) begin : g_pull
         assign pull_enable[ch] = tcfg_r[ch][2] && !tcfg_r[ch][1];
         assign pull_size_1m[ch] = tcfg_r[ch][0];
      end
   endgenerate

   // Time chain, copies and register file next state
   always_comb begin
      logic c;
      logic [7:0] nb;
      logic [7:0] ev;
      c = 1'b0;
      nb = BCD_ZERO;
      ev = BCD_ZERO;
      int_nxt = int_r;
      usr_nxt = usr_r;
      div_nxt = (tick || int_r[1][STOP_BIT]) ? 32'd0 : div_r + 32'd1;
      ctrl_nxt = ctrl_r;
      tcfg_nxt = tcfg_r;
      halt_nxt = halt_r;
      rdhold_nxt = rdhold_r;
      ack_nxt = take;
      rdata_nxt = rdata_r;
      // Internal BCD chain keeps counting whatever the copies do
      c = tick;
      if (c) begin
         c = (int_r[0] == BCD_SUBSEC_MAX);
         int_nxt[0] = rtu_bcd_next(int_r[0], BCD_SUBSEC_MAX, BCD_ZERO);
      end
      for (int i = 1; i < 3; i++) begin
         if (c) begin
            c = ({1'b0, int_r[i][6:0]} == BCD_SEC_MAX);
            nb = rtu_bcd_next({1'b0, int_r[i][6:0]}, BCD_SEC_MAX, BCD_ZERO);
            int_nxt[i][6:0] = nb[6:0];
         end
      end
      if (c) begin
         c = ({2'b00, int_r[3][5:0]} == BCD_HOUR_MAX);
         nb = rtu_bcd_next({2'b00, int_r[3][5:0]}, BCD_HOUR_MAX, BCD_ZERO);
         int_nxt[3][5:0] = nb[5:0];
         nb = rtu_bcd_next({5'b0, int_r[4][2:0]}, BCD_DAY_MAX, BCD_ONE);
         if (c) begin
            int_nxt[4][2:0] = nb[2:0];
         end
      end
      if (c) begin
         ev = rtu_month_days({3'b000, int_r[6][4:0]}, int_r[7]);
         c = ({2'b00, int_r[5][5:0]} >= ev);
         nb = rtu_bcd_next({2'b00, int_r[5][5:0]}, ev, BCD_ONE);
         int_nxt[5][5:0] = nb[5:0];
      end
      if (c) begin
         c = ({3'b000, int_r[6][4:0]} == BCD_MONTH_MAX);
         nb = rtu_bcd_next({3'b000, int_r[6][4:0]}, BCD_MONTH_MAX, BCD_ONE);
         int_nxt[6][4:0] = nb[4:0];
      end
      if (c) begin
         c = (int_r[7] == BCD_YEAR_MAX);
         int_nxt[7] = rtu_bcd_next(int_r[7], BCD_YEAR_MAX, BCD_ZERO);
      end
      if (c) begin
         int_nxt[3][7:6] = int_r[3][7:6] + 2'b01;
      end
      // Copies follow the incremented chain unless frozen or being read
      // A read taken this cycle blocks the copy too, so the bytes that follow it match it
      if (!frozen && !rdhold_r && !(take && !bus.wr && bus.addr <= OFS_YEAR)) begin
         usr_nxt = int_nxt;
      end
      if (frozen) begin
         usr_nxt[0] = BCD_ZERO;
      end
      // Register writes
      if (take && bus.wr) begin
         if (clk_wr) begin
            usr_nxt = usr_r;
            usr_nxt[bus.addr[2:0]] = bus.wdata;
            usr_nxt[0] = BCD_ZERO;
            int_nxt = usr_nxt;
            div_nxt = 32'd0;
         end
         unique case (bus.addr)
            OFS_CONTROL: ctrl_nxt = bus.wdata;
            OFS_HALT: halt_nxt = bus.wdata[HALT_BIT];
            OFS_TAMPER1: tcfg_nxt[0] = {bus.wdata[ARM_BIT], bus.wdata[SWITCH_BIT], bus.wdata[PULL_BIT]};
            OFS_TAMPER2: tcfg_nxt[1] = {bus.wdata[ARM_BIT], bus.wdata[SWITCH_BIT], bus.wdata[PULL_BIT]};
            default: ;
         endcase
         rdhold_nxt = 1'b0;
      end
      // Read hold lasts while the pointer stays in the clock bytes
      if (take && !bus.wr) begin
         rdhold_nxt = (bus.addr <= OFS_YEAR);
         rdata_nxt = RST_BYTE;
         if (bus.addr <= OFS_YEAR) begin
            rdata_nxt = usr_r[bus.addr[2:0]];
         end else begin
            unique case (bus.addr)
               OFS_CONTROL: rdata_nxt = ctrl_r;
               OFS_HALT: rdata_nxt[HALT_BIT] = halt_r;
               OFS_FLAGS: rdata_nxt = {6'b0, flag_r[0], flag_r[1]};
               OFS_TAMPER1: rdata_nxt = {tcfg_r[0][2], 1'b0, tcfg_r[0][1], 2'b00, tcfg_r[0][0], 2'b00};
               OFS_TAMPER2: rdata_nxt = {tcfg_r[1][2], 1'b0, tcfg_r[1][1], 2'b00, tcfg_r[1][0], 2'b00};
               default: ;
            endcase
         end
      end
      if (bus.stop) begin
         rdhold_nxt = 1'b0;
      end
      // Power return halts updates unless a tamper channel is armed; set wins
      if (pu_sync_r[1] && !pu_last_r && !(|arm)) begin
         halt_nxt = 1'b1;
      end
      // Flags set only while armed; cleared by disarming; set wins over clear
      for (int ch = 0; ch < 2; ch++) begin
         flag_nxt[ch] = (flag_r[ch] && tcfg_nxt[ch][2]) || (tp_s2_r[ch] && tcfg_r[ch][2]);
      end
   end

   // State registers
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         for (int i = 0; i < 8; i++) begin
            int_r[i] <= (i == 4 || i == 5 || i == 6) ? RST_DAY : RST_BYTE;
            usr_r[i] <= (i == 4 || i == 5 || i == 6) ? RST_DAY : RST_BYTE;
         end
         div_r <= 32'd0;
         ctrl_r <= RST_BYTE;
         tcfg_r[0] <= 3'b000;
         tcfg_r[1] <= 3'b000;
         flag_r <= 2'b00;
         halt_r <= 1'b0;
         rdhold_r <= 1'b0;
         ack_r <= 1'b0;
         rdata_r <= RST_BYTE;
         tp_s1_r <= 2'b00;
         tp_s2_r <= 2'b00;
         pu_sync_r <= 2'b00;
         pu_last_r <= 1'b0;
      end else begin
         int_r <= int_nxt;
         usr_r <= usr_nxt;
         div_r <= div_nxt;
         ctrl_r <= ctrl_nxt;
         tcfg_r <= tcfg_nxt;
         flag_r <= flag_nxt;
         halt_r <= halt_nxt;
         rdhold_r <= rdhold_nxt;
         ack_r <= ack_nxt;
         rdata_r <= rdata_nxt;
         tp_s1_r <= tamper_input_pin; // Pins are asynchronous, two stages first
         tp_s2_r <= tp_s1_r;
         pu_sync_r <= {pu_sync_r[0], power_up_event};
         pu_last_r <= pu_sync_r[1];
      end
   end
endmodule // rtu_device
`default_nettype wire

// File: design/rtu_host.sv
// Host controller: Avalon-MM command registers driving the register link
`default_nettype none
module rtu_host
   import rtu_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   rtu_if.host bus,
   input wire logic [1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest
);
   rtu_hstate_t st_r;
   rtu_hstate_t st_nxt;
   logic [7:0] addr_r;
   logic [7:0] addr_nxt;
   logic [7:0] wdata_r;
   logic [7:0] wdata_nxt;
   logic wr_r;
   logic wr_nxt;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;
   logic cmd_wr;

   // A new command stalls the bus master until the previous one is done
   assign cmd_wr = avs_write && (avs_address == AVS_CMD);
   assign avs_waitrequest = cmd_wr && (st_r != HS_IDLE);
   assign bus.req = (st_r == HS_REQ);
   assign bus.stop = (st_r == HS_STOP);
   assign bus.addr = addr_r;
   assign bus.wdata = wdata_r;
   assign bus.wr = wr_r;

   // Status readback; unmapped words read zero
   always_comb begin
      avs_readdata = 32'h0000_0000;
      if (avs_read && avs_address == AVS_STATUS) begin
         avs_readdata = {16'h0000, rdata_r, 7'b0, st_r != HS_IDLE};
      end
   end

   // Command sequencer; the host reads frozen time before disarming, by software order
   always_comb begin
      st_nxt = st_r;
      addr_nxt = addr_r;
      wdata_nxt = wdata_r;
      wr_nxt = wr_r;
      rdata_nxt = rdata_r;
      unique case (st_r)
         HS_IDLE: begin
            if (cmd_wr) begin
               addr_nxt = avs_writedata[7:0];
               wdata_nxt = avs_writedata[15:8];
               wr_nxt = avs_writedata[CMD_WR_BIT];
               st_nxt = avs_writedata[CMD_STOP_BIT] ? HS_STOP : HS_REQ;
            end
         end
         HS_REQ: begin
            if (bus.ack) begin
               if (!wr_r) begin
                  rdata_nxt = bus.rdata;
               end
               st_nxt = HS_IDLE;
            end
         end
         HS_STOP: st_nxt = HS_IDLE;
      endcase
   end

   // Sequencer registers
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         st_r <= HS_IDLE;
         addr_r <= RST_BYTE;
         wdata_r <= RST_BYTE;
         wr_r <= 1'b0;
         rdata_r <= RST_BYTE;
      end else begin
         st_r <= st_nxt;
         addr_r <= addr_nxt;
         wdata_r <= wdata_nxt;
         wr_r <= wr_nxt;
         rdata_r <= rdata_nxt;
      end
   end
endmodule // rtu_host
`default_nettype wire

// File: tb/rtu_checker.sv
// Link protocol and read-hold checks between host controller and clock device
`default_nettype none
module rtu_checker
   import rtu_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic req,
   input wire logic wr,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic [7:0] rdata,
   input wire logic ack,
   input wire logic stop
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   logic hold_r, hold_nxt;
   logic [7:0] ha_r, ha_nxt, hd_r, hd_nxt;
   logic rd_ack;
   assign rd_ack = ack && !wr;
   // Mirror of the read hold; stop, writes and reads past the clock bytes drop it
   always_comb begin
      hold_nxt = hold_r;
      ha_nxt = ha_r;
      hd_nxt = hd_r;
      if (stop || (ack && wr) || (rd_ack && addr > OFS_YEAR)) begin
         hold_nxt = 1'b0;
      end else if (rd_ack) begin
         hold_nxt = 1'b1;
         ha_nxt = addr;
         hd_nxt = rdata;
      end
   end
   always_ff @(posedge ref_clk) begin
      hold_r <= rst ? 1'b0 : hold_nxt;
      ha_r <= rst ? 8'h00 : ha_nxt;
      hd_r <= rst ? 8'h00 : hd_nxt;
   end
   property p_ack_next; req && !ack |=> ack; endproperty
   property p_ack_pulse; ack |=> !ack; endproperty
   property p_ack_cause; ack |-> req && $past(req); endproperty
   property p_req_hold; req && !ack |=> req && $stable(addr) && $stable(wr) && $stable(wdata); endproperty
   property p_req_drop; ack |=> !req; endproperty
   property p_stop_alone; stop |-> !req ##1 !stop; endproperty
   property p_rdata_keep; !rd_ack |-> $stable(rdata); endproperty
   property p_hold; rd_ack && hold_r && addr == ha_r |-> rdata == hd_r; endproperty
   property p_weekday; rd_ack && addr == OFS_WEEKDAY |-> rdata[2:0] != 3'h0; endproperty
   a_ack_next: assert property (p_ack_next) else $error("ack late");
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than a cycle");
   a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
   a_req_hold: assert property (p_req_hold) else $error("request changed before ack");
   a_req_drop: assert property (p_req_drop) else $error("request kept after ack");
   a_stop_alone: assert property (p_stop_alone) else $error("stop not a lone pulse");
   a_rdata_keep: assert property (p_rdata_keep) else $error("read data moved without read");
   a_hold: assert property (p_hold) else $error("clock byte changed during read hold");
   a_weekday: assert property (p_weekday) else $error("weekday field zero");
   c_hold: cover property (rd_ack && hold_r && addr == ha_r);
   c_write: cover property (ack && wr && addr <= OFS_YEAR);
   c_stop: cover property (stop);
endmodule // rtu_checker
`default_nettype wire

// File: tb/test_rtu_timestamp_update_control.sv
// Testbench: host controller and clock device joined over the register link
`default_nettype none
module test_rtc_timestamp_update_control
   import rtu_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk, rst, avs_read, avs_write, avs_waitrequest, power_up_event, osc_running;
   logic [1:0] avs_address, tamper_input_pin, pull_enable, pull_size_1m;
   logic [31:0] avs_writedata, avs_readdata;
   logic [7:0] b, s1;
   int mismatches, tests_run;
   rtu_if link ();
   // Short subsecond count keeps second rollover at 400 cycles
   rtu_device #(.SUBSEC_CYCLES(4)) rtu_device_inst (.ref_clk(ref_clk), .rst(rst), .bus(link),
      .tamper_input_pin(tamper_input_pin), .power_up_event(power_up_event), .pull_enable(pull_enable),
      .pull_size_1m(pull_size_1m), .osc_running(osc_running));
   rtu_host rtu_host_inst (.ref_clk(ref_clk), .rst(rst), .bus(link), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
   rtu_checker rtu_checker_inst (.ref_clk(ref_clk), .rst(rst), .req(link.req), .wr(link.wr),
      .addr(link.addr), .wdata(link.wdata), .rdata(link.rdata), .ack(link.ack), .stop(link.stop));
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // One Avalon access; request held until waitrequest is sampled low
   task automatic av(input logic [1:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
      @(posedge ref_clk);
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= d;
      @(posedge ref_clk iff avs_waitrequest == 1'b0);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   // Issue a link command and poll busy until it has finished
   task automatic op(input logic [7:0] a, input logic [7:0] d, input logic w, input logic s, output logic [7:0] r);
      logic [31:0] q;
      av(AVS_CMD, 1'b1, {14'h0, s, w, d, a}, q);
      q = 32'h1;
      while (q[0] === 1'b1) av(AVS_STATUS, 1'b0, 32'h0, q);
      r = q[15:8];
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] r);
      op(a, 8'h00, 1'b0, 1'b0, r);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] r;
      op(a, d, 1'b1, 1'b0, r);
   endtask
   task automatic stp();
      logic [7:0] r;
      op(8'h00, 8'h00, 1'b0, 1'b1, r);
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic t_reset();
      logic [31:0] q;
      chk({osc_running, pull_enable, pull_size_1m}, 5'h10);
      rd(OFS_WEEKDAY, b);
      chk(b, RST_DAY);
      rd(OFS_CONTROL, b);
      chk(b, RST_BYTE);
      av(2'h2, 1'b0, 32'h0, q);
      chk(q, 32'h0);
      // A command straight behind another must be stalled while the link is busy
      av(AVS_CMD, 1'b1, {24'h00_0000, OFS_CONTROL}, q);
      @(posedge ref_clk);
      avs_address <= AVS_CMD;
      avs_write <= 1'b1;
      avs_writedata <= {24'h00_0000, OFS_CONTROL};
      @(posedge ref_clk);
      chk(avs_waitrequest, 1'b1);
      @(posedge ref_clk iff avs_waitrequest == 1'b0);
      avs_write <= 1'b0;
      q = 32'h1;
      while (q[0] === 1'b1) av(AVS_STATUS, 1'b0, 32'h0, q);
      chk(q[15:8], RST_BYTE);
      $display("reset test done");
   endtask
   task automatic t_set();
      logic [7:0] tv [8];
      tv = '{8'h55, 8'h30, 8'h45, 8'hC5, 8'h03, 8'h15, 8'h08, 8'h24};
      // Halted copies keep what is written, so every byte but the subseconds (forced to 00) reads back directly
      wr(OFS_HALT, 8'h40);
      for (int i = 7; i >= 0; i--) wr(8'(i), tv[i]);
      for (int i = 0; i < 8; i++) begin
         rd(8'(i), b);
         chk(b, (i == 0) ? 8'h00 : tv[i]);
      end
      wr(OFS_SECONDS, 8'hB0);
      chk(osc_running, 1'b0);
      wr(OFS_SECONDS, 8'h30);
      chk(osc_running, 1'b1);
      wr(OFS_HALT, 8'h00);
      // With copies running, a written subsecond byte must restart near zero
      wr(OFS_SUBSEC, 8'h55);
      rd(OFS_SUBSEC, b);
      chk(b < 8'h10, 1'b1);
      stp();
      wt(1000);
      rd(OFS_SECONDS, b);
      chk(b > 8'h31 && b <= BCD_SEC_MAX, 1'b1);
      $display("set test done");
   endtask
   task automatic t_hold();
      stp();
      rd(OFS_SUBSEC, s1);
      wt(40);
      rd(OFS_SUBSEC, b);
      chk(b, s1);
      rd(OFS_CONTROL, b);
      wt(40);
      rd(OFS_SUBSEC, b);
      chk(b !== s1, 1'b1);
      rd(OFS_SUBSEC, s1);
      stp();
      wt(40);
      rd(OFS_SUBSEC, b);
      chk(b !== s1, 1'b1);
      $display("hold test done");
   endtask
   task automatic t_tamper();
      // Channel two is normally open, so it must get no pull resistor
      wr(OFS_TAMPER1, 8'h84);
      wr(OFS_TAMPER2, 8'hA0);
      chk({pull_enable, pull_size_1m}, 4'h5);
      stp();
      tamper_input_pin <= 2'b01;
      wt(6);
      rd(OFS_FLAGS, b);
      chk(b, 8'h02);
      rd(OFS_SUBSEC, b);
      chk(b, 8'h00);
      rd(OFS_SECONDS, s1);
      stp();
      wt(500);
      tamper_input_pin <= 2'b11;
      wt(6);
      rd(OFS_SECONDS, b);
      chk(b, s1);
      wr(OFS_FLAGS, 8'h00);
      rd(OFS_FLAGS, b);
      chk(b, 8'h03);
      tamper_input_pin <= 2'b00;
      wr(OFS_TAMPER1, 8'h04);
      rd(OFS_FLAGS, b);
      chk(b, 8'h01);
      wr(OFS_TAMPER2, 8'h00);
      stp();
      wt(500);
      rd(OFS_SECONDS, b);
      chk({b !== s1, pull_enable}, 3'h4);
      $display("tamper test done");
   endtask
   task automatic t_power();
      // An armed channel must keep the power-return edge from halting copies
      wr(OFS_TAMPER2, 8'h80);
      power_up_event <= 1'b1;
      wt(4);
      power_up_event <= 1'b0;
      rd(OFS_HALT, b);
      chk(b[HALT_BIT], 1'b0);
      wr(OFS_TAMPER2, 8'h00);
      power_up_event <= 1'b1;
      wt(4);
      power_up_event <= 1'b0;
      rd(OFS_HALT, b);
      chk(b[HALT_BIT], 1'b1);
      rd(OFS_SUBSEC, b);
      chk(b, 8'h00);
      // The host keeps its own copy of the power-down time
      rd(OFS_SECONDS, s1);
      stp();
      wt(500);
      rd(OFS_SECONDS, b);
      chk(b, s1);
      wr(OFS_HALT, 8'h00);
      stp();
      wt(500);
      rd(OFS_SECONDS, b);
      chk(b !== s1, 1'b1);
      $display("power test done");
   endtask
   initial begin
      {rst, avs_read, avs_write, power_up_event} = 4'h8;
      {avs_address, tamper_input_pin, avs_writedata} = 36'h0;
      {mismatches, tests_run} = 64'h0;
      wt(8);
      rst <= 1'b0;
      t_reset();
      t_set();
      t_hold();
      t_tamper();
      t_power();
      print_verdict();
   end
   // Tests need about 4k cycles; this cuts a hang short
   initial begin
      wt(60000);
      mismatches++;
      print_verdict();
   end
endmodule // test_rtc_timestamp_update_control
`default_nettype wire
